// file: pkg/debug_uart_regs.vh
`ifndef DEBUG_UART_REGS_VH
`define DEBUG_UART_REGS_VH
// register byte offsets
`define OFS_CONTROL_COMMAND   8'h00
`define OFS_MODE_SETUP        8'h04
`define OFS_IRQ_ENABLE_SET    8'h08
`define OFS_IRQ_ENABLE_CLEAR  8'h0C
`define OFS_IRQ_ENABLE_STATE  8'h10
`define OFS_LINE_STATUS       8'h14
`define OFS_RX_HOLDING        8'h18
`define OFS_TX_HOLDING        8'h1C
`define OFS_BAUD_DIVISOR      8'h20
`define OFS_PART_IDENTITY     8'h40
`define OFS_PART_ID_EXT       8'h44
`define OFS_DEBUG_LOCKOUT     8'h48
// control_command bits
`define CR_RX_RESET           2
`define CR_TX_RESET           3
`define CR_RX_ENABLE          4
`define CR_RX_DISABLE         5
`define CR_TX_ENABLE          6
`define CR_TX_DISABLE         7
`define CR_ERR_CLEAR          8
// mode_setup fields
`define MR_PAR_LSB            9
`define MR_PAR_MSB            11
`define MR_CHANNEL_TEST_MODE_LSB         14
`define MR_CHANNEL_TEST_MODE_MSB         15
// status / mask bit positions
`define SR_RX_AVAIL           0
`define SR_TX_FREE            1
`define SR_RX_DMA_END         3
`define SR_TX_DMA_END         4
`define SR_OVERRUN            5
`define SR_FRAMING            6
`define SR_PARITY             7
`define SR_TX_IDLE            9
`define SR_TX_DMA_BUFE        11
`define SR_RX_DMA_BUFF        12
`define SR_DBG_WRITE          30
`define SR_DBG_READ           31
`define SR_IMPL_MASK          32'hC0001AFB
// reset values
`define MR_RESET              32'h00000000
`define BRGR_RESET            16'h0000
`define MASK_RESET            32'h00000000
// identity values are arbitrary
`define PART_ID_VALUE         32'h12345670
`define PART_ID_EXT_VALUE     32'h00000000
// parity and channel mode codes
`define PAR_EVEN              3'h0
`define PAR_ODD               3'h1
`define PAR_SPACE             3'h2
`define PAR_MARK              3'h3
`define CH_NORMAL             2'h0
`define CH_ECHO               2'h1
`define CH_LOCAL              2'h2
`define CH_REMOTE             2'h3
`endif

// file: verilog/debug_uart.v
// Behaviour
// - rx reset bit aborts and disables receiver
// - tx reset bit aborts and disables transmitter
// - rx enable works only without rx disable
// - rx disable finishes current character first
// - tx enable works only without tx disable
// - tx disable drains shift and holding first
// - error clear bit clears three error flags
// - parity field selects even odd space mark none
// - channel mode selects normal echo local remote
// - enable-set writes set mask bits
// - enable-clear writes clear mask bits
// - mask state readable, resets to zero
// - common bit layout for mask and status
// - rx available until read or disabled
// - tx free unless holding full or disabled
// - tx idle when nothing pending, enabled
// - error flags sticky until cleared
// - dma end flags mirror dma inputs
// - dma buffer flags mirror dma inputs
// - top bits mirror debug channel pending
// - start, eight data lsb first, parity, stop
// - unread character overwritten sets overrun
// - parity mismatch sets parity error
// - low stop bit sets framing error
`timescale 1ns/100ps
`include "debug_uart_regs.vh"
module debug_uart (
   // clock and reset
   input  wire        clk,
   input  wire        reset_n,
   // ahb-lite slave
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   // serial pins
   input  wire        serialInPin,
   output reg         serialOutPin,
   // dma channel and debug channel status
   input  wire        rxDmaEnd,
   input  wire        txDmaEnd,
   input  wire        txDmaBufferEmpty,
   input  wire        rxDmaBufferFull,
   input  wire        debugChanWritePending,
   input  wire        debugChanReadPending,
   // interrupt and lockout
   output reg         irq,
   output reg         debugPortLockout
);
   localparam RX_IDLE  = 2'h0;
   localparam RX_START = 2'h1;
   localparam RX_DATA  = 2'h2;
   localparam RX_STOP  = 2'h3;
   localparam TX_IDLE  = 2'h0;
   localparam TX_START = 2'h1;
   localparam TX_DATA  = 2'h2;
   localparam TX_STOP  = 2'h3;

   // input synchronisers
   reg  [5:0]  syncA_q;
   reg  [5:0]  syncB_q;
   wire        rxPin   = syncB_q[0];
   // bus state
   reg         wrPend_q;
   reg         rdPend_q;
   reg  [7:0]  addr_q;
   // registers
   reg  [31:0] mode_q;
   reg  [15:0] baud_q;
   reg  [31:0] mask_q;
   reg         rx_enable_cmd_q;
   reg         tx_enable_cmd_q;
   reg         rxDisPend_q;
   reg         txDisPend_q;
   reg         rxAvail_q;
   reg         ovr_q;
   reg         frm_q;
   reg         par_q;
   reg  [7:0]  rxHold_q;
   reg  [7:0]  txHold_q;
   reg         txHoldFull_q;
   // baud tick
   reg  [19:0] baudCnt_q;
   reg         tick16_q;
   // receiver
   reg  [1:0]  rxSt_q;
   reg  [3:0]  rxSub_q;
   reg  [3:0]  rxBit_q;
   reg  [8:0]  rxShift_q;
   // transmitter
   reg  [1:0]  txSt_q;
   reg  [3:0]  txSub_q;
   reg  [3:0]  txBit_q;
   reg  [8:0]  txShift_q;
   reg         txLine_q;

   wire        bWr   = wrPend_q;
   wire [31:0] cmd   = hwdata;
   wire        wrCr  = bWr && (addr_q == `OFS_CONTROL_COMMAND);
   wire        wrThr = bWr && (addr_q == `OFS_TX_HOLDING);
   wire        rdRhr = rdPend_q && (addr_q == `OFS_RX_HOLDING);
   wire [2:0]  parType = mode_q[`MR_PAR_MSB:`MR_PAR_LSB];
   wire [1:0]  channel_test_mode  = mode_q[`MR_CHANNEL_TEST_MODE_MSB:`MR_CHANNEL_TEST_MODE_LSB];
   wire        parOn   = ~parType[2];
   wire        rxRst   = wrCr && cmd[`CR_RX_RESET];
   wire        txRst   = wrCr && cmd[`CR_TX_RESET];
   wire        errClr  = wrCr && cmd[`CR_ERR_CLEAR];
   // remote loopback disables transmitter and receiver
   wire        rxActive = rx_enable_cmd_q && (channel_test_mode != `CH_REMOTE);
   wire        txActive = tx_enable_cmd_q && (channel_test_mode != `CH_REMOTE);
   wire        rxIn = (channel_test_mode == `CH_LOCAL) ? txLine_q : rxPin;

   // parity bit for eight data bits
   function parBit;
      input [7:0] d;
      input [2:0] t;
      begin
         case (t[1:0])
            2'h0: parBit = ^d;
            2'h1: parBit = ~(^d);
            2'h2: parBit = 1'b0;
            default: parBit = 1'b1;
         endcase
      end
   endfunction

   wire [31:0] status;
   assign status[`SR_RX_AVAIL]    = rxAvail_q;
   assign status[`SR_TX_FREE]     = tx_enable_cmd_q && !txHoldFull_q;
   assign status[2]               = 1'b0;
   assign status[`SR_RX_DMA_END]  = syncB_q[1];
   assign status[`SR_TX_DMA_END]  = syncB_q[2];
   assign status[`SR_OVERRUN]     = ovr_q;
   assign status[`SR_FRAMING]     = frm_q;
   assign status[`SR_PARITY]      = par_q;
   assign status[8]               = 1'b0;
   assign status[`SR_TX_IDLE]     = tx_enable_cmd_q && !txHoldFull_q && txSt_q == TX_IDLE;
   assign status[10]              = 1'b0;
   assign status[`SR_TX_DMA_BUFE] = syncB_q[3];
   assign status[`SR_RX_DMA_BUFF] = syncB_q[4];
   assign status[29:13]           = 17'h00000;
   assign status[`SR_DBG_WRITE]   = debugChanWritePending;
   assign status[`SR_DBG_READ]    = syncB_q[5];

   // synchronise asynchronous inputs
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         syncA_q <= 6'h01;
         syncB_q <= 6'h01;
      end else begin
         syncA_q <= {debugChanReadPending, rxDmaBufferFull, txDmaBufferEmpty,
                     txDmaEnd, rxDmaEnd, serialInPin};
         syncB_q <= syncA_q;
      end
   end

   // ahb-lite slave: zero wait states, always okay
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wrPend_q  <= 1'b0;
         rdPend_q  <= 1'b0;
         addr_q    <= 8'h00;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= 32'h00000000;
      end else begin
         wrPend_q <= hsel && hready && htrans[1] && hwrite;
         rdPend_q <= hsel && hready && htrans[1] && !hwrite;
         if (hsel && hready && htrans[1]) begin
            addr_q <= (haddr[31:8] == 24'h000000) ? {haddr[7:2], 2'h0} : 8'hFC;
         end
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (hsel && hready && htrans[1] && !hwrite) begin
            if (haddr[31:8] != 24'h000000) begin
               hrdata <= 32'h00000000;
            end else if ({haddr[7:2], 2'h0} == `OFS_MODE_SETUP) begin
               hrdata <= {16'h0000, mode_q[15:14], 2'h0, mode_q[11:9], 9'h000};
            end else if ({haddr[7:2], 2'h0} == `OFS_IRQ_ENABLE_STATE) begin
               hrdata <= mask_q;
            end else if ({haddr[7:2], 2'h0} == `OFS_LINE_STATUS) begin
               hrdata <= status;
            end else if ({haddr[7:2], 2'h0} == `OFS_RX_HOLDING) begin
               hrdata <= {24'h000000, rxHold_q};
            end else if ({haddr[7:2], 2'h0} == `OFS_BAUD_DIVISOR) begin
               hrdata <= {16'h0000, baud_q};
            end else if ({haddr[7:2], 2'h0} == `OFS_PART_IDENTITY) begin
               hrdata <= `PART_ID_VALUE;
            end else if ({haddr[7:2], 2'h0} == `OFS_PART_ID_EXT) begin
               hrdata <= `PART_ID_EXT_VALUE;
            end else if ({haddr[7:2], 2'h0} == `OFS_DEBUG_LOCKOUT) begin
               hrdata <= {31'h00000000, debugPortLockout};
            end else begin
               hrdata <= 32'h00000000;
            end
         end
      end
   end

   // configuration, mask, interrupt
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_q           <= `MR_RESET;
         baud_q           <= `BRGR_RESET;
         mask_q           <= `MASK_RESET;
         debugPortLockout <= 1'b0;
         irq              <= 1'b0;
      end else begin
         if (bWr && addr_q == `OFS_MODE_SETUP) begin
            mode_q <= cmd & 32'h0000CE00;
         end
         if (bWr && addr_q == `OFS_BAUD_DIVISOR) begin
            baud_q <= cmd[15:0];
         end
         if (bWr && addr_q == `OFS_DEBUG_LOCKOUT) begin
            debugPortLockout <= cmd[0];
         end
         if (bWr && addr_q == `OFS_IRQ_ENABLE_SET) begin
            mask_q <= mask_q | (cmd & `SR_IMPL_MASK);
         end else if (bWr && addr_q == `OFS_IRQ_ENABLE_CLEAR) begin
            mask_q <= mask_q & ~(cmd & `SR_IMPL_MASK);
         end
         irq <= |(status & mask_q);
      end
   end

   // baud tick: 16x oversampling, divisor 1 runs at clock rate
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         baudCnt_q <= 20'h00000;
         tick16_q  <= 1'b0;
      end else if (baud_q == 16'h0000) begin
         baudCnt_q <= 20'h00000;
         tick16_q  <= 1'b0;
      end else if (baudCnt_q + 20'h00001 >= {4'h0, baud_q}) begin
         baudCnt_q <= 20'h00000;
         tick16_q  <= 1'b1;
      end else begin
         baudCnt_q <= baudCnt_q + 20'h00001;
         tick16_q  <= 1'b0;
      end
   end

   // receiver
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_enable_cmd_q      <= 1'b0;
         rxDisPend_q <= 1'b0;
         rxSt_q      <= RX_IDLE;
         rxSub_q     <= 4'h0;
         rxBit_q     <= 4'h0;
         rxShift_q   <= 9'h000;
         rxHold_q    <= 8'h00;
         rxAvail_q   <= 1'b0;
         ovr_q       <= 1'b0;
         frm_q       <= 1'b0;
         par_q       <= 1'b0;
      end else begin
         if (errClr) begin
            ovr_q <= 1'b0;
            frm_q <= 1'b0;
            par_q <= 1'b0;
         end
         if (rdRhr) begin
            rxAvail_q <= 1'b0;
         end
         if (rxRst) begin
            rx_enable_cmd_q      <= 1'b0;
            rxDisPend_q <= 1'b0;
            rxSt_q      <= RX_IDLE;
            rxAvail_q   <= 1'b0;
         end else begin
            if (wrCr && cmd[`CR_RX_DISABLE]) begin
               if (rxSt_q == RX_IDLE) begin
                  rx_enable_cmd_q <= 1'b0;
               end else begin
                  rxDisPend_q <= 1'b1;
               end
            end else if (wrCr && cmd[`CR_RX_ENABLE]) begin
               rx_enable_cmd_q      <= 1'b1;
               rxDisPend_q <= 1'b0;
            end
            if (!rx_enable_cmd_q) begin
               rxAvail_q <= 1'b0;
            end
            if (rxActive && tick16_q) begin
               case (rxSt_q)
                  RX_IDLE: begin
                     if (!rxIn) begin
                        rxSt_q  <= RX_START;
                        rxSub_q <= 4'h0;
                     end
                  end
                  RX_START: begin
                     rxSub_q <= rxSub_q + 4'h1;
                     if (rxSub_q == 4'h7) begin
                        rxSub_q <= 4'h0;
                        rxBit_q <= 4'h0;
                        rxSt_q  <= rxIn ? RX_IDLE : RX_DATA;
                     end
                  end
                  RX_DATA: begin
                     rxSub_q <= rxSub_q + 4'h1;
                     if (rxSub_q == 4'hF) begin
                        rxShift_q <= {rxIn, rxShift_q[8:1]};
                        rxBit_q   <= rxBit_q + 4'h1;
                        if (rxBit_q == (parOn ? 4'h8 : 4'h7)) begin
                           rxSt_q <= RX_STOP;
                        end
                     end
                  end
                  default: begin
                     rxSub_q <= rxSub_q + 4'h1;
                     if (rxSub_q == 4'hF) begin
                        rxSt_q    <= RX_IDLE;
                        rxAvail_q <= 1'b1;
                        rxHold_q  <= parOn ? rxShift_q[7:0] : rxShift_q[8:1];
                        if (rxAvail_q && !rdRhr) begin
                           ovr_q <= 1'b1;
                        end
                        if (!rxIn) begin
                           frm_q <= 1'b1;
                        end
                        if (parOn && rxShift_q[8] != parBit(rxShift_q[7:0], parType)) begin
                           par_q <= 1'b1;
                        end
                        if (rxDisPend_q) begin
                           rx_enable_cmd_q      <= 1'b0;
                           rxDisPend_q <= 1'b0;
                        end
                     end
                  end
               endcase
            end
         end
      end
   end

   // transmitter
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tx_enable_cmd_q       <= 1'b0;
         txDisPend_q  <= 1'b0;
         txHold_q     <= 8'h00;
         txHoldFull_q <= 1'b0;
         txSt_q       <= TX_IDLE;
         txSub_q      <= 4'h0;
         txBit_q      <= 4'h0;
         txShift_q    <= 9'h1FF;
         txLine_q     <= 1'b1;
         serialOutPin <= 1'b1;
      end else begin
         case (channel_test_mode)
            `CH_ECHO:   serialOutPin <= rxPin;
            `CH_LOCAL:  serialOutPin <= 1'b1;
            `CH_REMOTE: serialOutPin <= rxPin;
            default:    serialOutPin <= txLine_q;
         endcase
         if (txRst) begin
            tx_enable_cmd_q       <= 1'b0;
            txDisPend_q  <= 1'b0;
            txHoldFull_q <= 1'b0;
            txSt_q       <= TX_IDLE;
            txLine_q     <= 1'b1;
         end else begin
            if (wrCr && cmd[`CR_TX_DISABLE]) begin
               if (txSt_q == TX_IDLE && !txHoldFull_q) begin
                  tx_enable_cmd_q <= 1'b0;
               end else begin
                  txDisPend_q <= 1'b1;
               end
            end else if (wrCr && cmd[`CR_TX_ENABLE]) begin
               tx_enable_cmd_q      <= 1'b1;
               txDisPend_q <= 1'b0;
            end
            if (wrThr && tx_enable_cmd_q) begin
               txHold_q     <= cmd[7:0];
               txHoldFull_q <= 1'b1;
            end
            if (txDisPend_q && txSt_q == TX_IDLE && !txHoldFull_q) begin
               tx_enable_cmd_q      <= 1'b0;
               txDisPend_q <= 1'b0;
            end
            case (txSt_q)
               TX_IDLE: begin
                  txLine_q <= 1'b1;
                  if (txActive && txHoldFull_q && !wrThr) begin
                     txShift_q    <= {parBit(txHold_q, parType), txHold_q};
                     txHoldFull_q <= 1'b0;
                     txSt_q       <= TX_START;
                     txSub_q      <= 4'h0;
                  end
               end
               TX_START: begin
                  txLine_q <= 1'b0;
                  if (tick16_q) begin
                     txSub_q <= txSub_q + 4'h1;
                     if (txSub_q == 4'hF) begin
                        txSt_q  <= TX_DATA;
                        txBit_q <= 4'h0;
                     end
                  end
               end
               TX_DATA: begin
                  txLine_q <= txShift_q[0];
                  if (tick16_q) begin
                     txSub_q <= txSub_q + 4'h1;
                     if (txSub_q == 4'hF) begin
                        txShift_q <= {1'b1, txShift_q[8:1]};
                        txBit_q   <= txBit_q + 4'h1;
                        if (txBit_q == (parOn ? 4'h8 : 4'h7)) begin
                           txSt_q <= TX_STOP;
                        end
                     end
                  end
               end
               default: begin
                  txLine_q <= 1'b1;
                  if (tick16_q) begin
                     txSub_q <= txSub_q + 4'h1;
                     if (txSub_q == 4'hF) begin
                        txSt_q <= TX_IDLE;
                     end
                  end
               end
            endcase
         end
      end
   end
endmodule

// file: verification/uart_terminal.sv
`timescale 1ns/100ps
module uart_terminal #(parameter int BIT_CLKS = 16) (
   // clock
   input  wire logic clk,
   // serial wires
   input  wire logic lineIn,
   output logic      lineOut
);
   logic       parOn = 1'b0;
   logic [7:0] rxData;
   logic       rxPar;
   logic       rxStop;
   int         rxCount = 0;
   initial lineOut = 1'b1;
   // one frame: start, data lsb first, optional parity, stop, then one idle bit
   task automatic send(input logic [7:0] d, input logic pe, input logic pb, input logic sb);
      logic [10:0] f;
      f = {sb, pb, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         if (i != 9 || pe) begin
            lineOut <= f[i];
            repeat (BIT_CLKS) @(posedge clk);
         end
      end
      lineOut <= 1'b1;
      repeat (BIT_CLKS) @(posedge clk);
   endtask
   // receiver samples mid-bit
   initial forever begin
      @(negedge lineIn);
      repeat (BIT_CLKS / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CLKS) @(posedge clk);
         rxData[i] = lineIn;
      end
      if (parOn) begin
         repeat (BIT_CLKS) @(posedge clk);
         rxPar = lineIn;
      end
      repeat (BIT_CLKS) @(posedge clk);
      rxStop = lineIn;
      rxCount++;
   end
endmodule

// file: verification/debug_uart_properties.sv
`timescale 1ns/100ps
`include "debug_uart_regs.vh"
module debug_uart_properties (
   // clock and reset
   input logic        clk,
   input logic        reset_n,
   // bus
   input logic        hsel,
   input logic [31:0] haddr,
   input logic [1:0]  htrans,
   input logic        hwrite,
   input logic        hready,
   input logic [31:0] hwdata,
   input logic [31:0] hrdata,
   // pins and flags
   input logic        serialOutPin,
   input logic        rxDmaEnd,
   input logic        debugChanWritePending,
   input logic        irq
);
   logic       aVld_q;
   logic       aWr_q;
   logic [8:0] aAdr_q;
   logic       maskEver_q;
   wire        dRd = aVld_q & ~aWr_q;
   wire        dWr = aVld_q & aWr_q;
   wire        stat = dRd && aAdr_q == 9'h014;
   wire        rsvd = aAdr_q[8] || aAdr_q > 9'h048 || (aAdr_q > 9'h020 && aAdr_q < 9'h040);
   // remember the address phase for its data phase
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         aVld_q <= 1'b0;
         aWr_q <= 1'b0;
         aAdr_q <= 9'h000;
         maskEver_q <= 1'b0;
      end else begin
         aVld_q <= hsel & hready & htrans[1];
         aWr_q <= hwrite;
         aAdr_q <= {|haddr[31:8], haddr[7:0]};
         maskEver_q <= maskEver_q | (dWr && aAdr_q == 9'h008 && hwdata != 32'h0);
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   AST_RSVD_ZERO: assert property (dRd && rsvd |-> hrdata == 32'h0)
      else $error("reserved offset read not zero");
   AST_MODE_BITS: assert property (dRd && aAdr_q == 9'h004 |-> (hrdata & ~32'h0000CE00) == 32'h0)
      else $error("mode bits outside fields");
   AST_MASK_BITS: assert property (dRd && aAdr_q == 9'h010 |-> (hrdata & ~`SR_IMPL_MASK) == 32'h0)
      else $error("mask reserved bits set");
   AST_STATUS_BITS: assert property (stat |-> (hrdata & ~`SR_IMPL_MASK) == 32'h0)
      else $error("status reserved bits set");
   AST_DBG_WRITE: assert property (stat |-> hrdata[30] == $past(debugChanWritePending))
      else $error("debug write flag mismatch");
   AST_DMA_END: assert property (stat && $past(rxDmaEnd, 2) == $past(rxDmaEnd, 3) &&
         $past(rxDmaEnd, 3) == $past(rxDmaEnd, 4) && $past(rxDmaEnd, 4) == $past(rxDmaEnd, 5)
         |-> hrdata[`SR_RX_DMA_END] == $past(rxDmaEnd, 3))
      else $error("rx dma end flag mismatch");
   AST_IRQ_QUIET: assert property (!maskEver_q |-> !irq)
      else $error("irq without any mask bit");
   AST_TX_RESET_IDLE: assert property (dWr && aAdr_q == 9'h000 && hwdata[`CR_TX_RESET] |=> ##[0:2] serialOutPin [*4])
      else $error("line not idle after tx reset");
   cover property (dRd && rsvd);
   cover property (dWr && aAdr_q == 9'h000 && hwdata[`CR_TX_RESET]);
   cover property ($rose(irq));
endmodule
bind debug_uart debug_uart_properties u_props (.clk(clk), .reset_n(reset_n), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
   .hrdata(hrdata), .serialOutPin(serialOutPin), .rxDmaEnd(rxDmaEnd),
   .debugChanWritePending(debugChanWritePending), .irq(irq));

// file: verification/tb_top.sv
`timescale 1ns/100ps
`include "debug_uart_regs.vh"
module tb_top;
   localparam [8:0] CMD = 9'h000, MODE = 9'h004, IEN = 9'h008, IDIS = 9'h00C, IMASK = 9'h010;
   localparam [8:0] STAT = 9'h014, RXH = 9'h018, TXH = 9'h01C, BAUD = 9'h020;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [5:0]  side = 6'h00;
   wire  [31:0] hrdata;
   wire         hreadyout;
   wire         serialIn;
   wire         serialOut;
   wire         irq;
   wire         hresp;
   wire         lock;
   logic [31:0] r;
   int          fails = 0;
   int          n_tests = 0;
   int          n;
   initial forever #2.5 clk = ~clk;
   debug_uart DUT (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .serialInPin(serialIn), .serialOutPin(serialOut),
      .rxDmaEnd(side[0]), .txDmaEnd(side[1]), .txDmaBufferEmpty(side[2]),
      .rxDmaBufferFull(side[3]), .debugChanWritePending(side[4]),
      .debugChanReadPending(side[5]), .irq(irq), .debugPortLockout(lock));
   uart_terminal term (.clk(clk), .lineIn(serialOut), .lineOut(serialIn));
   task automatic stop_test();
      $display("checks %0d errors %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic waitRdy();
      for (int i = 0; i < 50; i++) begin
         @(posedge clk);
         if (hreadyout === 1'b1)
            return;
      end
      fails++;
      stop_test();
   endtask
   task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {23'h0, a};
      hwrite <= w;
      waitRdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      waitRdy();
      r = hrdata;
   endtask
   task automatic wr(input logic [8:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rdc(input logic [8:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(r, exp);
   endtask
   task automatic waitChar(input int cnt);
      for (int i = 0; i < 600 && term.rxCount < cnt; i++) @(posedge clk);
      if (term.rxCount < cnt) begin
         fails++;
         stop_test();
      end
   endtask
   initial begin
      static logic [8:0] zs [9] = '{MODE, IMASK, STAT, RXH, BAUD, 9'h030, 9'h048, 9'h04C, 9'h100};
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      foreach (zs[i]) rdc(zs[i], 32'h0);
      wr(9'h030, 32'hFFFFFFFF);
      rdc(9'h030, 32'h0);
      wr(9'h048, 32'hFFFFFFFF);
      rdc(9'h048, 32'h1);
      chk({hresp, lock}, 2'b01);
      wr(MODE, 32'hFFFFFFFF);
      rdc(MODE, 32'h0000CE00);
      // mask set, clear, status mirrors and interrupt
      wr(IEN, 32'hFFFFFFFF);
      rdc(IMASK, `SR_IMPL_MASK);
      wr(IDIS, 32'h00000003);
      rdc(IMASK, `SR_IMPL_MASK & ~32'h3);
      side <= 6'h3F;
      repeat (6) @(posedge clk);
      rdc(STAT, 32'hC0001818);
      chk(irq, 1'b1);
      wr(IDIS, 32'hFFFFFFFF);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
      side <= 6'h00;
      // enables and parity types on the wire
      wr(BAUD, 32'h1);
      wr(MODE, 32'h0);
      wr(CMD, 32'hF0);
      rdc(STAT, 32'h0);
      wr(CMD, 32'h50);
      rdc(STAT, 32'h202);
      for (int p = 0; p < 5; p++) begin
         wr(MODE, p << `MR_PAR_LSB);
         term.parOn = (p < 4);
         n = term.rxCount;
         wr(TXH, 32'h61);
         waitChar(n + 1);
         chk({term.rxStop, term.rxData}, 9'h161);
         if (p < 4)
            chk(term.rxPar, 4'b1001 >> p & 1);
      end
      // holding full, then disable drains both characters
      repeat (20) @(posedge clk);
      n = term.rxCount;
      wr(TXH, 32'hA5);
      wr(TXH, 32'h3C);
      rdc(STAT, 32'h0);
      wr(CMD, 32'h80);
      waitChar(n + 2);
      chk(term.rxData, 8'h3C);
      repeat (20) @(posedge clk);
      rdc(STAT, 32'h0);
      // tx reset mid character
      wr(CMD, 32'h40);
      wr(TXH, 32'h00);
      repeat (40) @(posedge clk);
      wr(CMD, 32'h08);
      repeat (2) @(posedge clk);
      chk(serialOut, 1'b1);
      rdc(STAT, 32'h0);
      repeat (250) @(posedge clk);
      // receive, overrun, framing, parity, clear
      term.send(8'h3C, 1'b0, 1'b0, 1'b1);
      rdc(STAT, 32'h1);
      rdc(RXH, 32'h3C);
      rdc(STAT, 32'h0);
      term.send(8'h11, 1'b0, 1'b0, 1'b1);
      term.send(8'h22, 1'b0, 1'b0, 1'b1);
      rdc(STAT, 32'h21);
      term.send(8'h33, 1'b0, 1'b0, 1'b0);
      rdc(STAT, 32'h61);
      wr(MODE, `PAR_EVEN << `MR_PAR_LSB);
      term.send(8'h01, 1'b1, 1'b0, 1'b1);
      rdc(STAT, 32'hE1);
      wr(CMD, 32'h100);
      rdc(STAT, 32'h1);
      rdc(RXH, 32'h01);
      // rx reset abandons the character in flight
      fork
         term.send(8'h55, 1'b1, 1'b0, 1'b1);
         begin
            repeat (60) @(posedge clk);
            wr(CMD, 32'h04);
         end
      join
      wr(CMD, 32'h10);
      term.send(8'h5A, 1'b1, 1'b0, 1'b1);
      rdc(STAT, 32'h1);
      rdc(RXH, 32'h5A);
      // rx disable mid character still completes it
      fork
         term.send(8'h66, 1'b1, 1'b0, 1'b1);
         begin
            repeat (60) @(posedge clk);
            wr(CMD, 32'h20);
         end
      join
      rdc(STAT, 32'h0);
      rdc(RXH, 32'h66);
      wr(CMD, 32'h10);
      // echo and remote loopback return the frame, local loopback keeps the line idle
      for (int m = 1; m < 4; m += 2) begin
         wr(MODE, m << `MR_CHANNEL_TEST_MODE_LSB | 32'h800);
         term.send(8'hC3 + m, 1'b0, 1'b0, 1'b1);
         chk(term.rxData, 8'hC3 + m);
      end
      wr(MODE, 32'h8800);
      wr(CMD, 32'h40);
      wr(TXH, 32'h96);
      repeat (60) @(posedge clk);
      chk(serialOut, 1'b1);
      repeat (200) @(posedge clk);
      rdc(RXH, 32'h96);
      stop_test();
   end
endmodule
